// *** rtl/mis_pkg.sv ***
// package for the second motion-interrupt status block
// offsets, field positions, reset values and mode encodings
package mis_pkg;
  // ==========================================================
  // register offsets on the sensor register port
  localparam logic [7:0] STATUS_OFS = 8'h35;
  localparam logic [7:0] THRESH_OFS = 8'h36;
  localparam logic [7:0] DUR_OFS = 8'h37;
  // ==========================================================
  // field positions and widths
  localparam int ACTIVE_BIT = 6;
  localparam int FLAG_W = 6;
  localparam int VAL_W = 7;
  // event vector order: bit5 z high .. bit0 x low
  localparam int ZH_BIT = 5;
  localparam int ZL_BIT = 4;
  localparam int YH_BIT = 3;
  localparam int YL_BIT = 2;
  localparam int XH_BIT = 1;
  localparam int XL_BIT = 0;
  // ==========================================================
  // reset values and duration counter ceiling
  localparam logic [6:0] THRESH_RST = 7'h00;
  localparam logic [6:0] DUR_RST = 7'h00;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [6:0] DUR_MAX = 7'h7f;
  // ==========================================================
  // combination modes {and_or_combine_select, six_direction_enable}
  typedef enum logic [1:0] {
    MIS_OR_EVENTS = 2'h0,
    MIS_SIX_MOVE = 2'h1,
    MIS_AND_EVENTS = 2'h2,
    MIS_SIX_POS = 2'h3
  } mis_mode_t;
endpackage

// *** rtl/mis_axis_cmp.sv ***
// one axis compare: magnitude of a signed sample against the threshold
// assumes sample and threshold are steady in the cycle they are used
`timescale 1ns/1ps
module mis_axis_cmp #(
  parameter int DATA_W = 16
) (
  // sample and threshold
  input wire logic signed [DATA_W-1:0] sample_i,
  input wire logic [6:0] threshold_value_i,
  // compare results
  output logic high_o,
  output logic low_o
);
  // ==========================================================
  // magnitude scaled to seven bits, saturating on full scale
  logic [DATA_W-1:0] abs_val;
  logic [6:0] mag;
  always_comb begin
    abs_val = sample_i[DATA_W-1] ? DATA_W'(-sample_i) : DATA_W'(sample_i);
    mag = abs_val[DATA_W-1] ? 7'h7f : abs_val[DATA_W-2 -: 7];
  end
  // high above threshold, low below it
  assign high_o = (mag > threshold_value_i);
  assign low_o = (mag < threshold_value_i);
endmodule // mis_axis_cmp

// *** rtl/mis_second_status.sv ***
// second motion-interrupt generator: status, threshold, duration
// assumes one sample strobe per output data rate period and a
// register port already decoded from the serial bus
// Operation
// - active flag set when an interrupt event is generated, else 0, reset 0
// - six axis event flags read 1 once their event occurred, reset 0
// - reading the status register clears active flag and the pin, unless a new event hits in the same cycle
// - latched mode freezes flags until status read, then they refresh
// - status register is read-only; writes change nothing
// - seven-bit threshold, reset zero, compared for high and low events
// - seven-bit duration, reset zero; event needs condition held that long
// - one duration step is one output data rate sample period
// - each axis high or low event counts only when its enable is set
// - modes 00 or, 01 six-dir movement, 10 and, 11 six-dir position
`timescale 1ns/1ps
module mis_second_status #(
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // configuration held elsewhere
  input wire logic and_or_combine_select_i,
  input wire logic six_direction_enable_i,
  input wire logic [5:0] event_enable_i,
  input wire logic latch_enable_i,
  // samples, one strobe per output data rate period
  input wire logic sample_valid_i,
  input wire logic signed [DATA_W-1:0] accel_x_i,
  input wire logic signed [DATA_W-1:0] accel_y_i,
  input wire logic signed [DATA_W-1:0] accel_z_i,
  // interrupt pin
  output logic int2_o
);
  // ==========================================================
  // state
  logic [6:0] threshold_value_reg;
  logic [6:0] duration_value_reg;
  logic [5:0] flags_reg;
  logic interrupt_active_flag_reg;
  logic [6:0] dur_cnt_reg;
  logic [5:0] zone_reg;
  logic [5:0] raw_evt;
  logic [5:0] en_evt;
  logic cond;
  logic hit;
  logic status_rd;
  logic thresh_wr;
  logic dur_wr;
  logic one_hot_zone;
  mis_pkg::mis_mode_t mode;

  // ==========================================================
  // register decode
  assign status_rd = reg_rd_i && (reg_addr_i == mis_pkg::STATUS_OFS);
  assign thresh_wr = reg_wr_i && (reg_addr_i == mis_pkg::THRESH_OFS);
  assign dur_wr = reg_wr_i && (reg_addr_i == mis_pkg::DUR_OFS);
  assign mode = mis_pkg::mis_mode_t'({and_or_combine_select_i, six_direction_enable_i});

  // threshold register, top bit dropped
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      threshold_value_reg <= mis_pkg::THRESH_RST;
    end else if (thresh_wr) begin
      threshold_value_reg <= reg_wdata_i[6:0];
    end
  end

  // duration register, top bit dropped
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      duration_value_reg <= mis_pkg::DUR_RST;
    end else if (dur_wr) begin
      duration_value_reg <= reg_wdata_i[6:0];
    end
  end

  // read data, registered; status has no write path
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        mis_pkg::STATUS_OFS: reg_rdata_o <= {1'b0, interrupt_active_flag_reg, flags_reg};
        mis_pkg::THRESH_OFS: reg_rdata_o <= {1'b0, threshold_value_reg};
        mis_pkg::DUR_OFS: reg_rdata_o <= {1'b0, duration_value_reg};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // per-axis compare
  mis_axis_cmp #(.DATA_W(DATA_W)) u_cmp_x (
    .sample_i(accel_x_i),
    .threshold_value_i(threshold_value_reg),
    .high_o(raw_evt[mis_pkg::XH_BIT]),
    .low_o(raw_evt[mis_pkg::XL_BIT])
  );
  mis_axis_cmp #(.DATA_W(DATA_W)) u_cmp_y (
    .sample_i(accel_y_i),
    .threshold_value_i(threshold_value_reg),
    .high_o(raw_evt[mis_pkg::YH_BIT]),
    .low_o(raw_evt[mis_pkg::YL_BIT])
  );
  mis_axis_cmp #(.DATA_W(DATA_W)) u_cmp_z (
    .sample_i(accel_z_i),
    .threshold_value_i(threshold_value_reg),
    .high_o(raw_evt[mis_pkg::ZH_BIT]),
    .low_o(raw_evt[mis_pkg::ZL_BIT])
  );

  // ==========================================================
  // enable gating and combination
  assign en_evt = raw_evt & event_enable_i;
  assign one_hot_zone = (en_evt != 6'h00) && ((en_evt & (en_evt - 6'h01)) == 6'h00);
  always_comb begin
    unique case (mode)
      mis_pkg::MIS_OR_EVENTS: cond = |en_evt;
      mis_pkg::MIS_AND_EVENTS: cond = (event_enable_i != 6'h00) && (en_evt == event_enable_i);
      mis_pkg::MIS_SIX_POS: cond = one_hot_zone;
      mis_pkg::MIS_SIX_MOVE: cond = one_hot_zone && (en_evt != zone_reg);
    endcase
  end

  // duration counts samples, so its step follows the data rate
  assign hit = sample_valid_i && cond && (dur_cnt_reg >= duration_value_reg);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dur_cnt_reg <= 7'h00;
    end else if (sample_valid_i) begin
      if (!cond) begin
        dur_cnt_reg <= 7'h00;
      end else if (dur_cnt_reg != mis_pkg::DUR_MAX) begin
        dur_cnt_reg <= dur_cnt_reg + 7'h01;
      end
    end
  end

  // last recognised six-direction zone, for movement mode
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      zone_reg <= mis_pkg::FLAGS_RST;
    end else if (sample_valid_i && one_hot_zone) begin
      zone_reg <= en_evt;
    end
  end

  // ==========================================================
  // event flags: follow samples, frozen in latched mode while active
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      flags_reg <= mis_pkg::FLAGS_RST;
    end else if (sample_valid_i && !(latch_enable_i && interrupt_active_flag_reg && !status_rd)) begin
      flags_reg <= en_evt;
    end
  end

  // active flag: a new hit wins over the clearing read
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      interrupt_active_flag_reg <= 1'b0;
    end else if (hit) begin
      interrupt_active_flag_reg <= 1'b1;
    end else if (status_rd) begin
      interrupt_active_flag_reg <= 1'b0;
    end else if (sample_valid_i && !latch_enable_i) begin
      interrupt_active_flag_reg <= 1'b0;
    end
  end

  // pin follows the flag
  assign int2_o = interrupt_active_flag_reg;

  // ==========================================================
  // checks
  sequence status_read_s;
    status_rd && !hit;
  endsequence
  sequence frozen_s;
    latch_enable_i && interrupt_active_flag_reg && !status_rd;
  endsequence

  AST_PIN_FOLLOWS: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(int2_o) |-> $past(hit))
    else $error("pin rose without an event");
  AST_PIN_FALLS: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(int2_o) |-> $past(status_rd || (sample_valid_i && !latch_enable_i)))
    else $error("pin fell without read or quiet sample");
  AST_READ_CLEARS: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    status_read_s |=> !interrupt_active_flag_reg && !int2_o)
    else $error("status read did not clear active");
  AST_HIT_SETS: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    hit |=> interrupt_active_flag_reg)
    else $error("event did not set active");
  AST_LATCH_FREEZE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    frozen_s |=> $stable(flags_reg))
    else $error("latched flags changed before read");
  AST_STATUS_RO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    reg_wr_i && (reg_addr_i == mis_pkg::STATUS_OFS) && !sample_valid_i |=> $stable(flags_reg))
    else $error("write changed status flags");
  AST_THS_WRITE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    thresh_wr |=> threshold_value_reg == $past(reg_wdata_i[6:0]))
    else $error("threshold not stored");
  AST_MSB_ZERO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    reg_rd_i |=> !reg_rdata_o[7])
    else $error("top read bit not zero");
  AST_DUR_ZERO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sample_valid_i && cond && (duration_value_reg == 7'h00) |=> interrupt_active_flag_reg)
    else $error("zero duration did not fire at once");
  AST_DUR_BLOCK: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sample_valid_i && !cond |=> (dur_cnt_reg == 7'h00))
    else $error("duration count not restarted");
  AST_GATED: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sample_valid_i && (event_enable_i == 6'h00) |-> !hit)
    else $error("disabled events raised a hit");
  AST_RESET: assert property (@(posedge clk_sys_i)
    !rst_n_i |=> (flags_reg == 6'h00) && !interrupt_active_flag_reg && (threshold_value_reg == 7'h00))
    else $error("reset values wrong");
endmodule // mis_second_status

// *** bench/mis_host_model.sv ***
// host model: drives the register port one strobe at a time
// assumes the bench calls wr and rd from a single process
`timescale 1ns/1ps
module mis_host_model (
  // clock
  input wire logic clk_sys_i,
  // register port
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  // ==========================================================
  // idle bus
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // one write; released lines show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
    @(posedge clk_sys_i);
    #1;
  endtask
  // one read; data registered at the taking edge and held after
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
    @(posedge clk_sys_i);
    #1;
  endtask
endmodule // mis_host_model

// *** bench/test_mis_second_status.sv ***
// testbench for the second motion-interrupt status block
// assumes 16-bit samples: magnitude field is bits 14:8 of the absolute value
`timescale 1ns/1ps
module test_mis_second_status;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr, wdata, rdata, rv;
  logic wr, rd, and_or_combine_select = 1'b0, sixd = 1'b0, latch = 1'b0, sv = 1'b0, int2;
  logic [5:0] ena = 6'h00;
  logic signed [15:0] ax = 16'sh0000, ay = 16'sh0000, az = 16'sh0000;
  int fail_count = 0;
  int cmp_count = 0;
  // ==========================================================
  // clock and instances
  initial forever #20 clk_sys_i = ~clk_sys_i;
  mis_host_model host (.clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_wdata_o(wdata), .reg_rdata_i(rdata));
  mis_second_status #(.DATA_W(16)) DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .and_or_combine_select_i(and_or_combine_select), .six_direction_enable_i(sixd),
    .event_enable_i(ena), .latch_enable_i(latch), .sample_valid_i(sv),
    .accel_x_i(ax), .accel_y_i(ay), .accel_z_i(az), .int2_o(int2));
  // ==========================================================
  // helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic smp(input logic [15:0] x, input logic [15:0] y);
    ax = x;
    ay = y;
    az = 16'sh1000;
    sv = 1'b1;
    @(posedge clk_sys_i);
    #1;
    sv = 1'b0;
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #(40 * 5000);
    fail_count++;
    close_out();
  end
  // ==========================================================
  // test sequence
  initial begin
    logic [3:0] one_hit, two_hit;
    one_hit = 4'b1011;
    two_hit = 4'b0101;
    repeat (16) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b1;
    // reset values and unmapped read
    host.rd(8'h35, rv); check(rv, 8'h00);
    host.rd(8'h36, rv); check(rv, 8'h00);
    host.rd(8'h37, rv); check(rv, 8'h00);
    host.rd(8'h38, rv); check(rv, 8'h00);
    // top bit dropped, status not writable
    host.wr(8'h36, 8'hff); host.rd(8'h36, rv); check(rv, 8'h7f);
    host.wr(8'h37, 8'h80); host.rd(8'h37, rv); check(rv, 8'h00);
    host.wr(8'h35, 8'hff); host.rd(8'h35, rv); check(rv, 8'h00);
    host.wr(8'h36, 8'h10); host.rd(8'h36, rv); check(rv, 8'h10);
    // disabled event ignored, enabled one raises pin and flags
    ena = 6'h02;
    smp(16'sh0000, 16'sh2000); check({7'h00, int2}, 8'h00);
    smp(16'sh2000, 16'sh0000); check({7'h00, int2}, 8'h01);
    host.rd(8'h35, rv); check(rv, 8'h42);
    check({7'h00, int2}, 8'h00);
    // every combination mode, single and double hit
    ena = 6'h0a;
    for (int m = 0; m < 4; m++) begin
      {and_or_combine_select, sixd} = 2'(m);
      smp(16'sh1000, 16'sh1000);
      // single hit alternates x and y so movement mode always sees a new zone
      smp(m[0] ? 16'sh1000 : 16'sh2000, m[0] ? 16'sh2000 : 16'sh1000);
      check({7'h00, int2}, {7'h00, one_hit[m]});
      smp(16'sh2000, 16'sh2000); check({7'h00, int2}, {7'h00, two_hit[m]});
      host.rd(8'h35, rv);
    end
    {and_or_combine_select, sixd} = 2'b00;
    // latched: flags frozen until read, then refresh
    ena = 6'h03;
    latch = 1'b1;
    smp(16'sh1000, 16'sh1000);
    host.rd(8'h35, rv);
    smp(16'sh2000, 16'sh0000);
    smp(16'sh0000, 16'sh0000);
    host.rd(8'h35, rv); check(rv, 8'h42);
    smp(16'sh0000, 16'sh0000);
    host.rd(8'h35, rv); check(rv, 8'h41);
    latch = 1'b0;
    // duration two: fires on the third consecutive sample
    ena = 6'h02;
    host.wr(8'h37, 8'h02);
    smp(16'sh1000, 16'sh1000);
    host.rd(8'h35, rv);
    smp(16'sh2000, 16'sh0000); check({7'h00, int2}, 8'h00);
    smp(16'sh2000, 16'sh0000); check({7'h00, int2}, 8'h00);
    smp(16'sh2000, 16'sh0000); check({7'h00, int2}, 8'h01);
    close_out();
  end
endmodule // test_mis_second_status
